// ===== dram_ctrl.v
`include "dram_ctrl_consts.vh"
module dram_ctrl (
    mclk,
    rst_n,
    low_power,
    cbr_mode,
    req_valid,
    req_op,
    req_page,
    req_row,
    req_col,
    req_wdata,
    req_ready,
    rsp_valid,
    rsp_rdata,
    ras_n,
    cas_n,
    we_n,
    oe_n,
    mux_address_pins,
    dq_out,
    dq_oe,
    dq_in
);
    parameter POWERUP_CYCLES = `POWERUP_CYC;
    parameter IDLE_CYCLES = `IDLE_CYC;
    parameter REFI_STD = `REFI_STD_CYC;
    parameter REFI_LP = `REFI_LP_CYC;
    parameter PAGE_MAX = `PAGE_ROW_LOW_MAX_CYC;
    input wire mclk;
    input wire rst_n;
    input wire low_power;
    input wire cbr_mode;
    input wire req_valid;
    input wire [1:0] req_op;
    input wire req_page;
    input wire [`ROW_BITS-1:0] req_row;
    input wire [`ROW_BITS-1:0] req_col;
    input wire [`DATA_BITS-1:0] req_wdata;
    output reg req_ready;
    output reg rsp_valid;
    output reg [`DATA_BITS-1:0] rsp_rdata;
    output reg ras_n;
    output reg cas_n;
    output reg we_n;
    output reg oe_n;
    output reg [`ROW_BITS-1:0] mux_address_pins;
    output reg [`DATA_BITS-1:0] dq_out;
    output reg dq_oe;
    input wire [`DATA_BITS-1:0] dq_in;

    localparam S_PWR = 4'h0;
    localparam S_INIT_LO = 4'h1;
    localparam S_INIT_HI = 4'h2;
    localparam S_IDLE = 4'h3;
    localparam S_RAS = 4'h4;
    localparam S_COL = 4'h5;
    localparam S_CAS = 4'h6;
    localparam S_ACC = 4'h7;
    localparam S_WR = 4'h8;
    localparam S_CUP = 4'h9;
    localparam S_PRE = 4'hA;
    localparam S_REF_RAS = 4'hB;
    localparam S_CBR_CAS = 4'hC;
    localparam S_REF_HOLD = 4'hD;

    reg [3:0] st_q;
    reg [3:0] pulses_q;
    reg [`ROW_BITS-1:0] ref_row_q;
    reg [`ROW_BITS-1:0] row_q;
    reg [`ROW_BITS-1:0] col_q;
    reg [1:0] op_q;
    reg page_q;
    reg [`DATA_BITS-1:0] wd_q;
    reg [`CNT_BITS-1:0] refi_q;
    reg [`CNT_BITS-1:0] idle_q;
    reg [`CNT_BITS-1:0] page_cnt_q;
    reg ref_due_q;
    reg tmr_load;
    reg [`CNT_BITS-1:0] tmr_count;
    wire tmr_done;
    wire [`CNT_BITS-1:0] refi_lim;

    assign refi_lim = low_power ? REFI_LP[`CNT_BITS-1:0] : REFI_STD[`CNT_BITS-1:0];

    strobe_timer u_tmr (
        .mclk(mclk),
        .rst_n(rst_n),
        .load(tmr_load),
        .count(tmr_count),
        .done(tmr_done)
    );

    always @* begin
        tmr_load = 1'b0;
        tmr_count = {`CNT_BITS{1'b0}};
        if (st_q == S_PWR && pulses_q == 4'h0) begin
            tmr_load = 1'b1;
            tmr_count = POWERUP_CYCLES[`CNT_BITS-1:0];
        end
    end

    always @(posedge mclk or negedge rst_n) begin
        if (!rst_n) begin
            st_q <= S_PWR;
            pulses_q <= 4'h0;
            ref_row_q <= {`ROW_BITS{1'b0}};
            row_q <= {`ROW_BITS{1'b0}};
            col_q <= {`ROW_BITS{1'b0}};
            op_q <= `OP_READ;
            page_q <= 1'b0;
            wd_q <= {`DATA_BITS{1'b0}};
            refi_q <= {`CNT_BITS{1'b0}};
            idle_q <= {`CNT_BITS{1'b0}};
            page_cnt_q <= {`CNT_BITS{1'b0}};
            ref_due_q <= 1'b0;
            req_ready <= 1'b0;
            rsp_valid <= 1'b0;
            rsp_rdata <= {`DATA_BITS{1'b0}};
            ras_n <= 1'b1;
            cas_n <= 1'b1;
            we_n <= 1'b1;
            oe_n <= 1'b1;
            mux_address_pins <= {`ROW_BITS{1'b0}};
            dq_out <= {`DATA_BITS{1'b0}};
            dq_oe <= 1'b0;
        end else begin
            rsp_valid <= 1'b0;
            req_ready <= 1'b0;
            // refresh demand; set wins over the clear in S_IDLE
            if (refi_q >= refi_lim - {{(`CNT_BITS-1){1'b0}}, 1'b1}) begin
                refi_q <= {`CNT_BITS{1'b0}};
                ref_due_q <= 1'b1;
            end else begin
                refi_q <= refi_q + {{(`CNT_BITS-1){1'b0}}, 1'b1};
            end
            if (ras_n && idle_q < IDLE_CYCLES[`CNT_BITS-1:0]) begin
                idle_q <= idle_q + {{(`CNT_BITS-1){1'b0}}, 1'b1};
            end else if (!ras_n) begin
                idle_q <= {`CNT_BITS{1'b0}};
            end
            page_cnt_q <= page_cnt_q + {{(`CNT_BITS-3){1'b0}}, `PH_CYC};
            case (st_q)
                S_PWR: begin
                    pulses_q <= 4'h1;
                    if (pulses_q != 4'h0 && tmr_done) begin
                        pulses_q <= 4'h0;
                        st_q <= S_INIT_LO;
                    end
                end
                S_INIT_LO: begin
                    if (idle_q != {`CNT_BITS{1'b0}}) begin // second high cycle for precharge
                        ras_n <= 1'b0;
                        pulses_q <= pulses_q + 4'h1;
                        st_q <= S_INIT_HI;
                    end
                end
                S_INIT_HI: begin
                    ras_n <= 1'b1;
                    if (pulses_q == `INIT_PULSES) begin
                        st_q <= S_IDLE;
                    end else begin
                        st_q <= S_INIT_LO;
                    end
                end
                S_IDLE: begin
                    we_n <= 1'b1;
                    if (idle_q >= IDLE_CYCLES[`CNT_BITS-1:0]) begin
                        pulses_q <= 4'h0;
                        idle_q <= {`CNT_BITS{1'b0}};
                        st_q <= S_INIT_LO;
                    end else if (ref_due_q) begin
                        ref_due_q <= (refi_q >= refi_lim - {{(`CNT_BITS-1){1'b0}}, 1'b1});
                        if (cbr_mode) begin
                            cas_n <= 1'b0;
                            st_q <= S_CBR_CAS;
                        end else begin
                            mux_address_pins <= ref_row_q;
                            ref_row_q <= ref_row_q + {{(`ROW_BITS-1){1'b0}}, 1'b1};
                            st_q <= S_REF_RAS;
                        end
                    end else if (req_valid) begin
                        req_ready <= 1'b1;
                        row_q <= req_row;
                        col_q <= req_col;
                        op_q <= req_op;
                        page_q <= req_page;
                        wd_q <= req_wdata;
                        mux_address_pins <= req_row;
                        st_q <= S_RAS;
                    end
                end
                S_RAS: begin
                    ras_n <= 1'b0;
                    page_cnt_q <= {`CNT_BITS{1'b0}};
                    st_q <= S_COL;
                end
                S_COL: begin
                    // a full cycle of row hold before column strobe
                    mux_address_pins <= col_q;
                    we_n <= (op_q != `OP_WRITE);
                    dq_out <= wd_q;
                    dq_oe <= (op_q == `OP_WRITE);
                    oe_n <= (op_q == `OP_WRITE);
                    st_q <= S_CAS;
                end
                S_CAS: begin
                    cas_n <= 1'b0;
                    st_q <= S_ACC;
                end
                S_ACC: begin
                    // one cycle covers the access times at this clock rate
                    if (op_q != `OP_WRITE) begin
                        rsp_rdata <= dq_in;
                        rsp_valid <= 1'b1;
                    end
                    if (op_q == `OP_RMW) begin
                        oe_n <= 1'b1;
                        st_q <= S_WR;
                    end else begin
                        oe_n <= 1'b1;
                        // write keeps we_n low until the column strobe rises
                        st_q <= S_CUP;
                    end
                end
                S_WR: begin
                    we_n <= 1'b0;
                    dq_out <= wd_q;
                    dq_oe <= 1'b1;
                    st_q <= S_CUP;
                end
                S_CUP: begin
                    cas_n <= 1'b1;
                    we_n <= 1'b1;
                    dq_oe <= 1'b0;
                    oe_n <= 1'b1;
                    if (page_q && req_valid && !ref_due_q && req_row == row_q &&
                        page_cnt_q < PAGE_MAX[`CNT_BITS-1:0] - `PAGE_TAIL_CYC) begin
                        req_ready <= 1'b1;
                        col_q <= req_col;
                        op_q <= req_op;
                        page_q <= req_page;
                        wd_q <= req_wdata;
                        st_q <= S_COL;
                    end else begin
                        st_q <= S_PRE;
                    end
                end
                S_PRE: begin
                    ras_n <= 1'b1;
                    st_q <= S_IDLE;
                end
                S_REF_RAS: begin
                    ras_n <= 1'b0;
                    st_q <= S_REF_HOLD;
                end
                S_CBR_CAS: begin
                    ras_n <= 1'b0;
                    st_q <= S_REF_HOLD;
                end
                S_REF_HOLD: begin
                    ras_n <= 1'b1;
                    cas_n <= 1'b1;
                    st_q <= S_IDLE;
                end
                default: begin
                    st_q <= S_IDLE;
                end
            endcase
        end
    end
endmodule

// ===== dram_ctrl_checker.sv
module dram_ctrl_checker #(
    parameter POWERUP_CYCLES = 2000,
    parameter REFI_STD = 156,
    parameter REFI_LP = 1248,
    parameter PAGE_MAX = 2000
) (
    input wire mclk,
    input wire rst_n,
    input wire low_power,
    input wire req_ready,
    input wire ras_n,
    input wire cas_n,
    input wire we_n,
    input wire oe_n,
    input wire dq_oe
);
    timeunit 1ns;
    timeprecision 100ps;
    logic [23:0] up_q;
    logic [23:0] gap_q;
    logic [23:0] low_q;
    logic [3:0] falls_q;
    logic ras_q;
    // up_q and falls_q saturate so long runs never wrap into a false pass
    always @(posedge mclk or negedge rst_n) begin
        if (!rst_n) begin
            up_q <= 24'h0;
            gap_q <= 24'h0;
            low_q <= 24'h0;
            falls_q <= 4'h0;
            ras_q <= 1'b1;
        end else begin
            ras_q <= ras_n;
            if (up_q != 24'hFFFFFF) up_q <= up_q + 24'h1;
            gap_q <= ras_n ? gap_q + 24'h1 : 24'h0;
            low_q <= ras_n ? 24'h0 : low_q + 24'h1;
            if (ras_q && !ras_n && falls_q != 4'hF) falls_q <= falls_q + 4'h1;
        end
    end
    default clocking cb @(posedge mclk);
    endclocking
    default disable iff (!rst_n);
    property p_powerup;
        up_q < POWERUP_CYCLES |-> ras_n && cas_n;
    endproperty
    a_powerup: assert property (p_powerup) else $error("strobe active in power-up pause");
    property p_init;
        req_ready |-> falls_q >= 4'h8;
    endproperty
    a_init: assert property (p_init) else $error("request taken before eight row pulses");
    property p_order;
        $fell(cas_n) && !ras_n |-> !$past(ras_n);
    endproperty
    a_order: assert property (p_order) else $error("column strobe not after row strobe");
    property p_read_setup;
        $fell(cas_n) && !ras_n && !oe_n |-> we_n && $past(we_n);
    endproperty
    a_read_setup: assert property (p_read_setup) else $error("write enable low at read");
    property p_precharge;
        $rose(ras_n) |=> ras_n;
    endproperty
    a_precharge: assert property (p_precharge) else $error("row precharge too short");
    property p_page_end;
        $rose(ras_n) |-> cas_n;
    endproperty
    a_page_end: assert property (p_page_end) else $error("row strobe rose before column");
    property p_cbr_we;
        $fell(ras_n) && !cas_n |-> we_n && $past(we_n);
    endproperty
    a_cbr_we: assert property (p_cbr_we) else $error("write enable low at refresh");
    property p_late_write;
        $fell(we_n) && !cas_n |-> oe_n ##1 oe_n;
    endproperty
    a_late_write: assert property (p_late_write) else $error("output enable low in write");
    property p_dq_drive;
        dq_oe |-> !we_n && oe_n;
    endproperty
    a_dq_drive: assert property (p_dq_drive) else $error("data driven outside write");
    property p_refi;
        falls_q >= 4'h8 |-> gap_q <= (low_power ? REFI_LP : REFI_STD) + 30;
    endproperty
    a_refi: assert property (p_refi) else $error("refresh interval exceeded");
    property p_page_max;
        low_q <= PAGE_MAX;
    endproperty
    a_page_max: assert property (p_page_max) else $error("row strobe low too long");
endmodule
bind dram_ctrl dram_ctrl_checker #(.POWERUP_CYCLES(POWERUP_CYCLES), .REFI_STD(REFI_STD),
    .REFI_LP(REFI_LP), .PAGE_MAX(PAGE_MAX)) dram_ctrl_checker_inst (.mclk(mclk), .rst_n(rst_n),
    .low_power(low_power), .req_ready(req_ready), .ras_n(ras_n), .cas_n(cas_n), .we_n(we_n),
    .oe_n(oe_n), .dq_oe(dq_oe));

// ===== dram_ctrl_consts.vh
`ifndef DRAM_CTRL_CONSTS_VH
`define DRAM_CTRL_CONSTS_VH
`define CLK_MHZ 10
`define POWERUP_US 200
`define POWERUP_CYC (`POWERUP_US * `CLK_MHZ)
`define INIT_PULSES 8
`define IDLE_MS 16
`define IDLE_CYC (`IDLE_MS * 1000 * `CLK_MHZ)
`define REFI_STD_NS 15600
`define REFI_LP_NS 124800
`define REFI_STD_CYC (`REFI_STD_NS / 100)
`define REFI_LP_CYC (`REFI_LP_NS / 100)
`define PAGE_ROW_LOW_MAX_NS 200000
`define PAGE_ROW_LOW_MAX_CYC (`PAGE_ROW_LOW_MAX_NS / 100)
`define ROW_BITS 10
`define DATA_BITS 4
`define CNT_BITS 24
`define OP_READ 2'h0
`define OP_WRITE 2'h1
`define OP_RMW 2'h2
`define PH_CYC 3'h1
`define PAGE_TAIL_CYC 24'h8
`endif

// ===== dram_model.sv
module dram_model (
    input wire ras_n,
    input wire cas_n,
    input wire we_n,
    input wire oe_n,
    input wire [9:0] mux_address_pins,
    input wire [3:0] dq_out,
    input wire dq_oe,
    output wire [3:0] dq_in
);
    timeunit 1ns;
    timeprecision 100ps;
    logic [3:0] mem [logic [19:0]];
    logic [9:0] row_q = 10'h0;
    logic [9:0] col_q = 10'h0;
    logic [9:0] ro_last = 10'h0;
    logic [3:0] rd_q = 4'h0;
    logic [3:0] last_q = 4'h0;
    logic col_seen = 1'b0;
    logic cbr = 1'b0;
    int ro_cnt = 0;
    int ro_bad = 0;
    int cbr_cnt = 0;
    wire on = !cas_n && !oe_n && we_n;
    // no pull on the data lines: a released bus shows the inverse of the last word
    assign dq_in = on ? rd_q : ~last_q;
    always @(negedge on) last_q = rd_q;
    // 1 ns settle so registered pins launched on the same edge have landed
    always @(negedge ras_n) begin
        #1;
        col_seen = 1'b0;
        cbr = !cas_n;
        if (cbr) cbr_cnt++;
        else row_q = mux_address_pins;
    end
    always @(posedge ras_n) begin
        if (!col_seen && !cbr) begin
            if (ro_cnt > 0 && row_q != ro_last + 10'h1) ro_bad++;
            ro_last = row_q;
            ro_cnt++;
        end
    end
    always @(negedge cas_n) begin
        #1;
        if (!ras_n) begin
            col_q = mux_address_pins;
            col_seen = 1'b1;
            if (!we_n && dq_oe) mem[{row_q, col_q}] = dq_out;
            rd_q = mem.exists({row_q, col_q}) ? mem[{row_q, col_q}] : 4'h5;
        end
    end
    always @(negedge we_n) begin
        #1;
        if (!ras_n && !cas_n && dq_oe) mem[{row_q, col_q}] = dq_out;
    end
endmodule

// ===== strobe_timer.v
`include "dram_ctrl_consts.vh"
module strobe_timer (
    mclk,
    rst_n,
    load,
    count,
    done
);
    input wire mclk;
    input wire rst_n;
    input wire load;
    input wire [`CNT_BITS-1:0] count;
    output wire done;
    reg [`CNT_BITS-1:0] cnt_q;
    assign done = (cnt_q == {`CNT_BITS{1'b0}});
    always @(posedge mclk or negedge rst_n) begin
        if (!rst_n) begin
            cnt_q <= {`CNT_BITS{1'b0}};
        end else if (load) begin
            cnt_q <= count;
        end else if (!done) begin
            cnt_q <= cnt_q - {{(`CNT_BITS-1){1'b0}}, 1'b1};
        end
    end
endmodule

// ===== testbench.sv
module testbench;
    timeunit 1ns;
    timeprecision 100ps;
    logic mclk = 0;
    logic rst_n = 0;
    logic low_power = 0;
    logic cbr_mode = 0;
    logic req_valid = 0;
    logic [1:0] req_op = 0;
    logic req_page = 0;
    logic [9:0] req_row = 0;
    logic [9:0] req_col = 0;
    logic [3:0] req_wdata = 0;
    wire req_ready, rsp_valid, ras_n, cas_n, we_n, oe_n, dq_oe;
    wire [3:0] rsp_rdata, dq_out, dq_in;
    wire [9:0] mux_address_pins;
    int n_errors = 0;
    int n_tests = 0;
    logic [3:0] shadow [logic [19:0]];
    logic [19:0] pool [8];
    always #50 mclk = ~mclk;
    dram_ctrl #(.POWERUP_CYCLES(20), .IDLE_CYCLES(200), .REFI_STD(40), .REFI_LP(90),
        .PAGE_MAX(2000)) dram_ctrl_inst (.mclk(mclk), .rst_n(rst_n), .low_power(low_power),
        .cbr_mode(cbr_mode), .req_valid(req_valid), .req_op(req_op), .req_page(req_page),
        .req_row(req_row), .req_col(req_col), .req_wdata(req_wdata), .req_ready(req_ready),
        .rsp_valid(rsp_valid), .rsp_rdata(rsp_rdata), .ras_n(ras_n), .cas_n(cas_n),
        .we_n(we_n), .oe_n(oe_n), .mux_address_pins(mux_address_pins), .dq_out(dq_out),
        .dq_oe(dq_oe), .dq_in(dq_in));
    dram_model dram_model_inst (.ras_n(ras_n), .cas_n(cas_n), .we_n(we_n), .oe_n(oe_n),
        .mux_address_pins(mux_address_pins), .dq_out(dq_out), .dq_oe(dq_oe), .dq_in(dq_in));
    task automatic check(input string what, input logic [15:0] seen, input logic [15:0] exp);
        n_tests++;
        if (seen !== exp) begin
            n_errors++;
            $display("wrong value %s expected %h seen %h", what, exp, seen);
        end
    endtask
    task automatic give_verdict;
        $display("errors %0d checks %0d", n_errors, n_tests);
        if (n_errors == 0 && n_tests > 0)
            $display("Testbench passed");
        else
            $display("Testbench failed");
        $finish;
    endtask
    // inputs stay up after ready so a page can continue without a gap
    task automatic do_req(input logic [1:0] op, input logic pg, input logic [19:0] a,
                          input logic [3:0] d);
        int i;
        logic [3:0] exp;
        exp = shadow.exists(a) ? shadow[a] : 4'h5;
        req_op = op;
        req_page = pg;
        req_row = a[19:10];
        req_col = a[9:0];
        req_wdata = d;
        req_valid = 1;
        for (i = 0; i < 3000; i++) begin
            @(negedge mclk);
            if (req_ready === 1'b1) break;
        end
        if (i == 3000) begin
            n_errors++;
            give_verdict;
        end
        if (op != 2'h1) begin
            for (i = 0; i < 20; i++) begin
                @(negedge mclk);
                if (rsp_valid === 1'b1) break;
            end
            if (i == 20) begin
                n_errors++;
                give_verdict;
            end
            check("read data", {12'h0, rsp_rdata}, {12'h0, exp});
        end
        if (op != 2'h0) shadow[a] = d;
    endtask
    initial begin
        int k;
        int e;
        int ro0;
        int cb0;
        k = $urandom(81);
        // four rows, two columns each, corners included
        pool[0] = 20'h00000;
        pool[1] = 20'h003FF;
        pool[2] = 20'hFFC00;
        pool[3] = 20'hFFFFF;
        for (k = 4; k < 8; k++) pool[k] = {k[0] ? pool[k - 1][19:10] : 10'($urandom), 10'($urandom)};
        repeat (5) @(negedge mclk);
        rst_n = 1;
        check("row strobe idle", {15'h0, ras_n}, 16'h1);
        for (k = 0; k < 8; k++) begin
            do_req(2'h1, 1'b0, pool[k], 4'(k + 9));
            if (k == 0) begin
                dram_model_inst.ro_cnt = 0;
                dram_model_inst.ro_bad = 0;
            end
        end
        for (int ph = 0; ph < 4; ph++) begin
            low_power = ph[1];
            cbr_mode = ph[0];
            ro0 = dram_model_inst.ro_cnt;
            cb0 = dram_model_inst.cbr_cnt;
            for (k = 0; k < 10; k++) begin
                e = 2 * $urandom_range(3);
                do_req(2'($urandom_range(2)), 1'b1, pool[e], 4'($urandom));
                do_req(2'($urandom_range(2)), 1'($urandom), pool[e + 1], 4'($urandom));
            end
            req_valid = 0;
            req_page = 0;
            repeat (150) @(negedge mclk);
            check("row refresh order", 16'(dram_model_inst.ro_bad), 16'h0);
            check("refresh kind", {dram_model_inst.cbr_cnt > cb0, dram_model_inst.ro_cnt > ro0},
                ph[0] ? 16'h2 : 16'h1);
        end
        rst_n = 0;
        repeat (3) @(negedge mclk);
        check("reset pins", {12'h0, ras_n, cas_n, dq_oe, req_ready}, 16'hC);
        rst_n = 1;
        for (k = 0; k < 8; k++) do_req(2'h0, 1'b0, pool[k], 4'h0);
        req_valid = 0;
        give_verdict;
    end
endmodule
